// file: logic/ddrm_module_pins.sv
// Dual-rank 72-bit DDR module: command decode, power states and data beats
// Notes on behaviour
// - Row, column and write-enable strobes form one command code; rank select only gates it.
// - Address and control sampled at the positive crossing of the clock pair.
// - Read data and strobes are launched from the clock pair crossings.
// - Clock gate high runs clock, inputs and outputs; low stops all three.
// - Gate low when idle gives precharge power-down or self refresh, else active.
// - Power-down entry, exit and self-refresh entry follow the sampled clock gate.
// - Clock receiver turn-on in self refresh and output disable follow clock gate without a clock edge.
// - In power-down only the clock pair and clock gate inputs stay live.
// - In self refresh only the clock gate input stays live.
// - A rank decodes commands only while its select is sampled low.
// - Bank selects pick one of four banks for activate, read, write, precharge.
// - Address carries row on activate and column on read or write.
// - Address bit ten on read or write closes the bank after the burst.
// - Precharge closes the selected bank, or all banks when bit ten is high.
// - Mode load takes the opcode from address; bank selects pick which register.
// - Module drives strobes with read data; controller strobes write data.
// - A high write mask blocks its byte lane; masks never affect reads.
// - Sixty-four data lines plus eight check bits form each beat.
// - Two beats per clock, one on each strobe and clock edge; here both beats move as parallel words on the positive crossing.
`timescale 1ns/1ps
`default_nettype none

module ddrm_module_pins (
  // System side
  input wire logic clk,
  input wire logic reset,
  output logic [1:0] rankPowerDown,
  output logic [1:0] rankSelfRefresh,
  output logic modeLoaded,
  // Clock pair crossing and per-rank controls
  input wire logic diffClockTrue,
  input wire logic rank0SelectN,
  input wire logic rank1SelectN,
  input wire logic rank0ClockGate,
  input wire logic rank1ClockGate,
  // Shared command and address
  input wire logic rowStrobeN,
  input wire logic columnStrobeN,
  input wire logic writeEnableN,
  input wire logic bankSelectLo,
  input wire logic bankSelectHi,
  input wire logic [ddrm_pkg::ADDR_WIDTH-1:0] addressLines,
  // Write beats, both taken at the positive crossing while the lane strobe is high
  input wire logic [ddrm_pkg::DATA_WIDTH-1:0] dataLinesIn0,
  input wire logic [ddrm_pkg::DATA_WIDTH-1:0] dataLinesIn1,
  input wire logic [ddrm_pkg::CHECK_WIDTH-1:0] checkBitsIn0,
  input wire logic [ddrm_pkg::CHECK_WIDTH-1:0] checkBitsIn1,
  input wire logic [ddrm_pkg::LANES-1:0] writeByteMasks0,
  input wire logic [ddrm_pkg::LANES-1:0] writeByteMasks1,
  input wire logic [ddrm_pkg::LANES-1:0] dataStrobesIn,
  // Read beats
  output logic [ddrm_pkg::DATA_WIDTH-1:0] dataLinesOut0,
  output logic [ddrm_pkg::DATA_WIDTH-1:0] dataLinesOut1,
  output logic [ddrm_pkg::CHECK_WIDTH-1:0] checkBitsOut0,
  output logic [ddrm_pkg::CHECK_WIDTH-1:0] checkBitsOut1,
  output logic [ddrm_pkg::LANES-1:0] dataStrobesOut0,
  output logic [ddrm_pkg::LANES-1:0] dataStrobesOut1,
  output logic dataOeN,
  // Rank power status and mode registers on the link side
  output logic [1:0] rankClockOn,
  output logic [1:0] rankInputBufOn,
  output logic [1:0] rankClockBufOn,
  output logic [ddrm_pkg::ADDR_WIDTH-1:0] modeRegister,
  output logic [ddrm_pkg::ADDR_WIDTH-1:0] extModeRegister
);

  typedef struct packed {
    logic [1:0] rstSync;
    logic [1:0][1:0] pwr;
    logic [1:0][3:0] open;
    logic [1:0][3:0] rowBit;
    logic [12:0] mode;
    logic [12:0] extMode;
    logic modeTog;
    logic rdValid;
    logic wrPend;
    logic apPend;
    logic [6:0] idx;
    logic [71:0] rd0;
    logic [71:0] rd1;
  } ddrm_link_type;

  typedef struct packed {
    logic [1:0] pd1;
    logic [1:0] pd2;
    logic [1:0] sr1;
    logic [1:0] sr2;
    logic [2:0] tog;
    logic pulse;
  } ddrm_sys_type;

  ddrm_link_type l;
  ddrm_link_type next_l;
  ddrm_sys_type s;
  ddrm_sys_type next_s;

  logic linkRst;
  logic [2:0] cmd;
  logic [1:0] bank;
  logic [1:0] gate;
  logic [1:0] selN;
  logic [1:0] live;
  logic rk;
  logic lmr;
  logic [6:0] cmdIdx;
  logic [71:0] rdA;
  logic [71:0] rdB;
  logic [71:0] wr0;
  logic [71:0] wr1;

  assign linkRst = l.rstSync[1];
  assign cmd = {rowStrobeN, columnStrobeN, writeEnableN};
  assign bank = {bankSelectHi, bankSelectLo};
  assign gate = {rank1ClockGate, rank0ClockGate};
  assign selN = {rank1SelectN, rank0SelectN};
  // Each rank listens only to its own select and gate
  assign live[0] = l.pwr[0] == ddrm_pkg::PWR_RUN && gate[0] && !selN[0];
  assign live[1] = l.pwr[1] == ddrm_pkg::PWR_RUN && gate[1] && !selN[1];
  // Rank 0 wins the data path if both ranks are selected at once
  assign rk = !live[0];
  assign cmdIdx = {rk, bank, l.rowBit[rk][bank], addressLines[ddrm_pkg::COL_BITS-1:0]};
  assign wr0 = {checkBitsIn0, dataLinesIn0};
  assign wr1 = {checkBitsIn1, dataLinesIn1};

  // Per-lane storage; lane 8 is the check byte
  for (genvar g = 0; g < ddrm_pkg::LANES; g++) begin : lane
    logic [7:0] mem [0:ddrm_pkg::MEM_DEPTH-1];
    // Gate is assumed high during the data beat, so no stall is kept here
    always_ff @(posedge diffClockTrue) begin
      if (l.wrPend && dataStrobesIn[g] && !writeByteMasks0[g]) begin
        mem[l.idx] <= wr0[g*ddrm_pkg::LANE_WIDTH +: ddrm_pkg::LANE_WIDTH];
      end
      if (l.wrPend && dataStrobesIn[g] && !writeByteMasks1[g]) begin
        mem[l.idx ^ 7'h01] <= wr1[g*ddrm_pkg::LANE_WIDTH +: ddrm_pkg::LANE_WIDTH];
      end
    end
    assign rdA[g*ddrm_pkg::LANE_WIDTH +: ddrm_pkg::LANE_WIDTH] = mem[cmdIdx];
    assign rdB[g*ddrm_pkg::LANE_WIDTH +: ddrm_pkg::LANE_WIDTH] = mem[cmdIdx ^ 7'h01];
  end

  always_comb begin
    next_l = l;
    lmr = 1'b0;
    next_l.rstSync = {l.rstSync[0], reset};
    next_l.rdValid = 1'b0;
    next_l.wrPend = 1'b0;
    next_l.apPend = 1'b0;
    next_l.idx = cmdIdx;
    next_l.rd0 = rdA;
    next_l.rd1 = rdB;
    // Auto precharge lands on the data beat, before any new command
    if (l.apPend && (l.rdValid || l.wrPend)) begin
      next_l.open[l.idx[6]][l.idx[5:4]] = 1'b0;
    end
    for (int r = 0; r < ddrm_pkg::RANKS; r++) begin
      if (live[r]) begin
        case (cmd)
          ddrm_pkg::CMD_ACT: begin
            next_l.open[r][bank] = 1'b1;
            next_l.rowBit[r][bank] = addressLines[0];
          end
          ddrm_pkg::CMD_PRE: begin
            if (addressLines[ddrm_pkg::AUTO_PRE_BIT]) begin
              next_l.open[r] = ddrm_pkg::OPEN_RESET;
            end else begin
              next_l.open[r][bank] = 1'b0;
            end
          end
          ddrm_pkg::CMD_LMR: begin
            lmr = 1'b1;
          end
          default: begin
          end
        endcase
      end
      // Gate sampled on the crossing decides entry and exit
      case (l.pwr[r])
        ddrm_pkg::PWR_RUN: begin
          if (!gate[r]) begin
            if (cmd == ddrm_pkg::CMD_REF && !selN[r] && l.open[r] == ddrm_pkg::OPEN_RESET) begin
              next_l.pwr[r] = ddrm_pkg::PWR_SELF;
            end else if (|l.open[r]) begin
              next_l.pwr[r] = ddrm_pkg::PWR_PDN_ACT;
            end else begin
              next_l.pwr[r] = ddrm_pkg::PWR_PDN_PRE;
            end
          end
        end
        default: begin
          if (gate[r]) begin
            next_l.pwr[r] = ddrm_pkg::PWR_RUN;
          end
        end
      endcase
    end
    if (live[rk] && l.open[rk][bank]) begin
      if (cmd == ddrm_pkg::CMD_RD) begin
        next_l.rdValid = 1'b1;
        next_l.apPend = addressLines[ddrm_pkg::AUTO_PRE_BIT];
      end else if (cmd == ddrm_pkg::CMD_WR) begin
        next_l.wrPend = 1'b1;
        next_l.apPend = addressLines[ddrm_pkg::AUTO_PRE_BIT];
      end
    end
    if (lmr) begin
      if (bank == ddrm_pkg::MODE_BASE) begin
        next_l.mode = addressLines;
      end else if (bank == ddrm_pkg::MODE_EXT) begin
        next_l.extMode = addressLines;
      end
      next_l.modeTog = !l.modeTog;
    end
    if (linkRst) begin
      next_l.pwr = {ddrm_pkg::PWR_RUN, ddrm_pkg::PWR_RUN};
      next_l.open = {ddrm_pkg::OPEN_RESET, ddrm_pkg::OPEN_RESET};
      next_l.rowBit = '0;
      next_l.mode = ddrm_pkg::MODE_RESET;
      next_l.extMode = ddrm_pkg::MODE_RESET;
      next_l.modeTog = 1'b0;
      next_l.rdValid = 1'b0;
      next_l.wrPend = 1'b0;
      next_l.apPend = 1'b0;
      next_l.idx = '0;
      next_l.rd0 = '0;
      next_l.rd1 = '0;
    end
  end

  // Whole link side moves on the positive crossing
  always_ff @(posedge diffClockTrue) begin
    l <= next_l;
  end

  // Power states only step between 00 and one other code, so OR and AND stay glitch free
  always_comb begin
    next_s.pd1 = {|l.pwr[1], |l.pwr[0]};
    next_s.pd2 = s.pd1;
    next_s.sr1 = {&l.pwr[1], &l.pwr[0]};
    next_s.sr2 = s.sr1;
    next_s.tog = {s.tog[1:0], l.modeTog};
    next_s.pulse = s.tog[1] ^ s.tog[2];
    if (reset) begin
      next_s = '0;
    end
  end

  always_ff @(posedge clk) begin
    s <= next_s;
  end

  assign rankPowerDown = s.pd2;
  assign rankSelfRefresh = s.sr2;
  assign modeLoaded = s.pulse;
  assign modeRegister = l.mode;
  assign extModeRegister = l.extMode;
  assign {checkBitsOut0, dataLinesOut0} = l.rd0;
  assign {checkBitsOut1, dataLinesOut1} = l.rd1;
  // Strobe high with the first beat and low with the second: edge aligned
  assign dataStrobesOut0 = {ddrm_pkg::LANES{l.rdValid}};
  assign dataStrobesOut1 = '0;
  // Raw gate pin turns drivers off at once, with no edge needed
  assign dataOeN = !(l.rdValid && gate[l.idx[6]]);
  assign rankClockOn = gate;
  assign rankInputBufOn = gate;
  // Clock receivers stay on in power-down, off in self refresh until gate rises
  assign rankClockBufOn[0] = gate[0] || l.pwr[0] != ddrm_pkg::PWR_SELF;
  assign rankClockBufOn[1] = gate[1] || l.pwr[1] != ddrm_pkg::PWR_SELF;

  default clocking @(posedge diffClockTrue); endclocking
  default disable iff (linkRst);

  a_cmd_masked: assert property (
    selN == 2'h3 |=> !l.rdValid && !l.wrPend)
    else $error("Command taken with both ranks deselected");
  a_read_beats: assert property (
    live[0] && cmd == ddrm_pkg::CMD_RD && l.open[0][bank] |=> l.rdValid && !l.idx[6]
    ##1 (!l.rdValid || $past(cmd == ddrm_pkg::CMD_RD)))
    else $error("Read beats not launched one crossing after read");
  a_oe_async: assert property (
    !gate[l.idx[6]] |-> dataOeN)
    else $error("Drivers on while rank clock gate low");
  a_pd_active: assert property (
    l.pwr[0] == ddrm_pkg::PWR_RUN && !gate[0] && (|l.open[0])
    |=> l.pwr[0] == ddrm_pkg::PWR_PDN_ACT && !rankInputBufOn[0])
    else $error("Open row did not enter active power-down");
  a_self_ref: assert property (
    l.pwr[0] == ddrm_pkg::PWR_RUN && !gate[0] && !selN[0] && cmd == ddrm_pkg::CMD_REF
    && l.open[0] == 4'h0 ##1 !gate[0] |-> l.pwr[0] == ddrm_pkg::PWR_SELF && !rankClockBufOn[0])
    else $error("Self refresh not entered or clock buffer left on");
  a_gate_sync: assert property (
    l.pwr[0] == ddrm_pkg::PWR_RUN && gate[0] |=> l.pwr[0] == ddrm_pkg::PWR_RUN)
    else $error("Power state left run with gate high");
  a_pre_all: assert property (
    live[0] && cmd == ddrm_pkg::CMD_PRE && addressLines[10] |=> l.open[0] == 4'h0)
    else $error("Precharge all left a bank open");
  a_pre_one: assert property (
    live[1] && cmd == ddrm_pkg::CMD_PRE && !addressLines[10] && bank == 2'h1 && !l.apPend
    |=> !l.open[1][1] && l.open[1][0] == $past(l.open[1][0])
    && l.open[1][3:2] == $past(l.open[1][3:2]))
    else $error("Single precharge touched the wrong bank");
  a_auto_pre: assert property (
    live[0] && (cmd == ddrm_pkg::CMD_RD || cmd == ddrm_pkg::CMD_WR) && l.open[0][3]
    && bank == 2'h3 && addressLines[10]
    ##1 !(live[0] && cmd == ddrm_pkg::CMD_ACT) |=> !l.open[0][3])
    else $error("Auto precharge did not close the bank");
  a_mode_load: assert property (
    live[0] && cmd == ddrm_pkg::CMD_LMR && bank == 2'h1 |=> extModeRegister == $past(addressLines))
    else $error("Extended mode register not loaded");
  a_mask_lane: assert property (
    l.wrPend && writeByteMasks0[0] |=> lane[0].mem[$past(l.idx)] == $past(lane[0].mem[l.idx]))
    else $error("Masked lane was written");

  c_read: cover property (l.rdValid && !dataOeN);
  c_write: cover property (l.wrPend && dataStrobesIn != 9'h000);
  c_self_exit: cover property (l.pwr[1] == ddrm_pkg::PWR_SELF ##1 l.pwr[1] == ddrm_pkg::PWR_RUN);

endmodule

`default_nettype wire

// file: logic/ddrm_note_unused.sv
// Intentionally empty; all logic lives in the module pin file
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: logic/ddrm_pkg.sv
// Shared widths, command codes and power states for the module pin block
package ddrm_pkg;
  localparam int RANKS = 2;
  localparam int BANKS = 4;
  localparam int ADDR_WIDTH = 13;
  localparam int DATA_WIDTH = 64;
  localparam int CHECK_WIDTH = 8;
  localparam int LANES = 9;
  localparam int LANE_WIDTH = 8;
  localparam int WORD_WIDTH = 72;
  localparam int IDX_WIDTH = 7;
  localparam int MEM_DEPTH = 128;
  localparam int COL_BITS = 3;
  localparam int AUTO_PRE_BIT = 10;
  // Command code {row strobe, column strobe, write enable}
  localparam logic [2:0] CMD_LMR = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  // Bank code selecting base or extended mode register
  localparam logic [1:0] MODE_BASE = 2'h0;
  localparam logic [1:0] MODE_EXT = 2'h1;
  // Values after reset
  localparam logic [12:0] MODE_RESET = 13'h0000;
  localparam logic [3:0] OPEN_RESET = 4'h0;
  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_PDN_PRE = 2'b01,
    PWR_PDN_ACT = 2'b10,
    PWR_SELF = 2'b11
  } ddrm_pwr_type;
endpackage

// file: testbench/ddrm_ctrl_model.sv
// Behavioural memory controller driving the module's command and write pins
`timescale 1ns/1ps
`default_nettype none

module ddrm_ctrl_model (
  // Link clock
  input wire logic diffClockTrue,
  // Command and control
  output logic rank0SelectN,
  output logic rank1SelectN,
  output logic rank0ClockGate,
  output logic rank1ClockGate,
  output logic rowStrobeN,
  output logic columnStrobeN,
  output logic writeEnableN,
  output logic bankSelectLo,
  output logic bankSelectHi,
  output logic [12:0] addressLines,
  // Write beats
  output logic [63:0] dataLinesIn0,
  output logic [63:0] dataLinesIn1,
  output logic [7:0] checkBitsIn0,
  output logic [7:0] checkBitsIn1,
  output logic [8:0] writeByteMasks0,
  output logic [8:0] writeByteMasks1,
  output logic [8:0] dataStrobesIn
);
  initial begin
    {rank1SelectN, rank0SelectN} = 2'h3;
    {rank1ClockGate, rank0ClockGate} = 2'h3;
    {rowStrobeN, columnStrobeN, writeEnableN} = 3'h7;
    {bankSelectHi, bankSelectLo} = 2'h0;
    addressLines = 13'h0000;
    {checkBitsIn0, dataLinesIn0, checkBitsIn1, dataLinesIn1} = 144'h0;
    {writeByteMasks1, writeByteMasks0, dataStrobesIn} = 27'h0000000;
  end

  // One command then a deselect cycle; gate level is kept afterwards
  task automatic cmd(input logic [1:0] selN, input logic [2:0] code, input logic [1:0] bank,
                     input logic [12:0] addr, input logic [1:0] gate);
    @(negedge diffClockTrue);
    {rank1SelectN, rank0SelectN} = selN;
    {rowStrobeN, columnStrobeN, writeEnableN} = code;
    {bankSelectHi, bankSelectLo} = bank;
    addressLines = addr;
    {rank1ClockGate, rank0ClockGate} = gate;
    @(negedge diffClockTrue);
    {rank1SelectN, rank0SelectN} = 2'h3;
    {rowStrobeN, columnStrobeN, writeEnableN} = 3'h7;
    {bankSelectHi, bankSelectLo} = ~bank;
    addressLines = ~addr;
  endtask

  // Released data lines show the inverse, never the stale word
  task automatic wr(input logic [1:0] selN, input logic [1:0] bank, input logic [12:0] addr,
                    input logic [71:0] w0, input logic [71:0] w1, input logic [8:0] k);
    cmd(selN, ddrm_pkg::CMD_WR, bank, addr, 2'h3);
    {checkBitsIn0, dataLinesIn0} = w0;
    {checkBitsIn1, dataLinesIn1} = w1;
    {writeByteMasks1, writeByteMasks0} = {k, k};
    dataStrobesIn = 9'h1ff;
    @(negedge diffClockTrue);
    {checkBitsIn0, dataLinesIn0} = ~w0;
    {checkBitsIn1, dataLinesIn1} = ~w1;
    dataStrobesIn = 9'h000;
  endtask

  // Gate change alone, off the sampling edge
  task automatic gates(input logic [1:0] g);
    @(negedge diffClockTrue);
    {rank1ClockGate, rank0ClockGate} = g;
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_ddrm_module_pins.sv
// Self-checking bench for the module pin block
`timescale 1ns/1ps
`default_nettype none

module tb_ddrm_module_pins;
  typedef struct packed {
    logic r; logic [1:0] b; logic [2:0] c; logic ap; logic [8:0] k; logic oe2;
  } ddrm_row_type;
  logic clk, reset, diffClockTrue;
  wire logic rank0SelectN, rank1SelectN, rank0ClockGate, rank1ClockGate, modeLoaded, dataOeN;
  wire logic rowStrobeN, columnStrobeN, writeEnableN, bankSelectLo, bankSelectHi;
  wire logic [12:0] addressLines, modeRegister, extModeRegister;
  wire logic [63:0] dataLinesIn0, dataLinesIn1, dataLinesOut0, dataLinesOut1;
  wire logic [7:0] checkBitsIn0, checkBitsIn1, checkBitsOut0, checkBitsOut1;
  wire logic [8:0] writeByteMasks0, writeByteMasks1, dataStrobesIn, dataStrobesOut0;
  wire logic [8:0] dataStrobesOut1;
  wire logic [1:0] rankPowerDown, rankSelfRefresh, rankClockOn, rankInputBufOn, rankClockBufOn;
  int errorCnt = 0;
  int compares = 0;
  int n;
  logic [1:0] sel;
  logic [71:0] a, b;
  // Second read repeats only while the bank stays open
  ddrm_row_type rows [5] = '{'{1'b0, 2'h0, 3'h0, 1'b0, 9'h000, 1'b0},
    '{1'b0, 2'h3, 3'h5, 1'b1, 9'h0ff, 1'b1}, '{1'b1, 2'h1, 3'h2, 1'b0, 9'h100, 1'b0},
    '{1'b1, 2'h2, 3'h7, 1'b1, 9'h0a5, 1'b1}, '{1'b0, 2'h2, 3'h3, 1'b0, 9'h1ff, 1'b0}};

  ddrm_module_pins uut (.clk, .reset, .rankPowerDown, .rankSelfRefresh, .modeLoaded,
    .diffClockTrue, .rank0SelectN, .rank1SelectN, .rank0ClockGate, .rank1ClockGate,
    .rowStrobeN, .columnStrobeN, .writeEnableN, .bankSelectLo, .bankSelectHi, .addressLines,
    .dataLinesIn0, .dataLinesIn1, .checkBitsIn0, .checkBitsIn1, .writeByteMasks0,
    .writeByteMasks1, .dataStrobesIn, .dataLinesOut0, .dataLinesOut1, .checkBitsOut0,
    .checkBitsOut1, .dataStrobesOut0, .dataStrobesOut1, .dataOeN, .rankClockOn,
    .rankInputBufOn, .rankClockBufOn, .modeRegister, .extModeRegister);
  ddrm_ctrl_model ctl (.diffClockTrue, .rank0SelectN, .rank1SelectN, .rank0ClockGate,
    .rank1ClockGate, .rowStrobeN, .columnStrobeN, .writeEnableN, .bankSelectLo,
    .bankSelectHi, .addressLines, .dataLinesIn0, .dataLinesIn1, .checkBitsIn0,
    .checkBitsIn1, .writeByteMasks0, .writeByteMasks1, .dataStrobesIn);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    diffClockTrue = 1'b0;
    #1.7;
    forever #3 diffClockTrue = ~diffClockTrue;
  end

  // Every lane differs so a swapped lane shows
  function automatic logic [71:0] pat(input logic [7:0] k);
    return {9{k}} ^ 72'h080706050403020100;
  endfunction
  function automatic logic [71:0] mix(input logic [71:0] w, input logic [71:0] o,
                                      input logic [8:0] k);
    for (int l = 0; l < 9; l++)
      if (k[l]) w[l*8 +: 8] = o[l*8 +: 8];
    return w;
  endfunction

  task automatic printVerdict();
    if (errorCnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [71:0] e, input logic [71:0] g);
    compares++;
    if (g !== e) begin
      errorCnt++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic bound(input int k, input int lim);
    if (k >= lim) begin
      errorCnt++;
      printVerdict();
    end
  endtask
  task automatic rd(input logic [1:0] s, input logic [1:0] bk, input logic [12:0] ad,
                    input logic oe, input logic [71:0] e0, input logic [71:0] e1);
    ctl.cmd(s, ddrm_pkg::CMD_RD, bk, ad, 2'h3);
    // Beats stand only from the command's edge to the next one
    chk("dataOeN", 72'(oe), 72'(dataOeN));
    if (oe === 1'b0) begin
      chk("beat0", e0, {checkBitsOut0, dataLinesOut0});
      chk("beat1", e1, {checkBitsOut1, dataLinesOut1});
      chk("strobes", 72'h1ff, 72'({dataStrobesOut1, dataStrobesOut0}));
    end
  endtask

  initial begin
    reset = 1'b1;
    repeat (12) @(negedge clk);
    chk("resetState", 72'h1, 72'({rankPowerDown, rankSelfRefresh, modeLoaded, modeRegister,
        extModeRegister, dataOeN}));
    reset = 1'b0;
    repeat (6) @(negedge diffClockTrue);
    for (int i = 0; i < 5; i++) begin
      sel = rows[i].r ? 2'h1 : 2'h2;
      a = pat(8'(i));
      b = pat(8'(i + 64));
      ctl.cmd(sel, ddrm_pkg::CMD_ACT, rows[i].b, 13'h0000, 2'h3);
      ctl.wr(sel, rows[i].b, {10'h000, rows[i].c}, a, ~a, 9'h000);
      ctl.wr(sel, rows[i].b, {10'h000, rows[i].c}, b, ~b, rows[i].k);
      rd(sel, rows[i].b, {2'h0, rows[i].ap, 7'h00, rows[i].c}, 1'b0, mix(b, a, rows[i].k),
         mix(~b, ~a, rows[i].k));
      rd(sel, rows[i].b, {10'h000, rows[i].c}, rows[i].oe2, mix(b, a, rows[i].k),
         mix(~b, ~a, rows[i].k));
    end
    rd(2'h3, 2'h0, 13'h0000, 1'b1, 72'h0, 72'h0);
    ctl.cmd(2'h2, ddrm_pkg::CMD_LMR, ddrm_pkg::MODE_BASE, 13'h0a5a, 2'h3);
    for (n = 0; n < 20 && modeLoaded !== 1'b1; n++) @(negedge clk);
    bound(n, 20);
    // Let the first pulse end so the next wait sees the second load
    @(negedge clk);
    ctl.cmd(2'h2, ddrm_pkg::CMD_LMR, ddrm_pkg::MODE_EXT, 13'h1234, 2'h3);
    for (n = 0; n < 20 && modeLoaded !== 1'b1; n++) @(negedge clk);
    bound(n, 20);
    chk("modes", 72'({13'h0a5a, 13'h1234}), 72'({modeRegister, extModeRegister}));
    // Active power-down on rank0 with bank0 open
    ctl.cmd(2'h3, 3'h7, 2'h0, 13'h0000, 2'h2);
    for (n = 0; n < 40 && rankPowerDown[0] !== 1'b1; n++) @(negedge clk);
    bound(n, 40);
    chk("pdnBufs", 72'h2b, 72'({rankSelfRefresh, rankClockOn, rankInputBufOn,
        rankClockBufOn}));
    ctl.cmd(2'h2, ddrm_pkg::CMD_RD, 2'h0, 13'h0000, 2'h2);
    chk("pdnRead", 72'h1, 72'(dataOeN));
    ctl.cmd(2'h3, 3'h7, 2'h0, 13'h0000, 2'h3);
    for (n = 0; n < 40 && rankPowerDown[0] !== 1'b0; n++) @(negedge clk);
    bound(n, 40);
    rd(2'h2, 2'h0, 13'h0000, 1'b0, pat(8'h40), ~pat(8'h40));
    ctl.cmd(2'h1, ddrm_pkg::CMD_ACT, 2'h2, 13'h0000, 2'h3);
    ctl.cmd(2'h1, ddrm_pkg::CMD_PRE, 2'h1, 13'h0000, 2'h3);
    rd(2'h1, 2'h1, 13'h0002, 1'b1, 72'h0, 72'h0);
    rd(2'h1, 2'h2, 13'h0007, 1'b0, mix(pat(8'h43), pat(8'h03), 9'h0a5),
       mix(~pat(8'h43), ~pat(8'h03), 9'h0a5));
    ctl.cmd(2'h2, ddrm_pkg::CMD_PRE, 2'h0, 13'h0400, 2'h3);
    rd(2'h2, 2'h2, 13'h0003, 1'b1, 72'h0, 72'h0);
    // Self refresh on rank0, all banks idle
    ctl.cmd(2'h2, ddrm_pkg::CMD_REF, 2'h0, 13'h0000, 2'h2);
    for (n = 0; n < 40 && rankSelfRefresh[0] !== 1'b1; n++) @(negedge clk);
    bound(n, 40);
    chk("selfBufs", 72'hc, 72'({rankPowerDown[0], rankClockBufOn, rankInputBufOn[0]}));
    ctl.gates(2'h3);
    #1;
    chk("wakeBufs", 72'h3, 72'(rankClockBufOn));
    for (n = 0; n < 40 && rankSelfRefresh[0] !== 1'b0; n++) @(negedge clk);
    bound(n, 40);
    printVerdict();
  end
endmodule
`default_nettype wire
